/* File: logic/ectm_consts.svh */
// constants of the eight bit compare timer: offsets, bit positions, reset values
`ifndef ECTM_CONSTS_SVH
`define ECTM_CONSTS_SVH

// ==========================================================================
// bus widths
`define ECTM_ADDR_W       16
`define ECTM_DATA_W       8

// ==========================================================================
// register byte addresses
`define ECTM_OFF_CTRL0    16'hffa0
`define ECTM_OFF_STAT     16'hffa1
`define ECTM_OFF_CORA     16'hffa2
`define ECTM_OFF_CORB     16'hffa3
`define ECTM_OFF_CNT      16'hffa4
`define ECTM_OFF_CTRL1    16'hffa5
`define ECTM_OFF_IRQ_STAT 16'hffa6
`define ECTM_OFF_IRQ_MASK 16'hffa7

// ==========================================================================
// status and control field positions
`define ECTM_ST_FLAG_LO   5
`define ECTM_ST_FLAG_HI   7
`define ECTM_ST_OSB_HI    3
`define ECTM_ST_OSB_LO    2
`define ECTM_ST_OSA_HI    1
`define ECTM_ST_OSA_LO    0
`define ECTM_C0_IE_HI     7
`define ECTM_C0_IE_LO     5
`define ECTM_C0_CCLR_HI   4
`define ECTM_C0_CCLR_LO   3
`define ECTM_C0_CKS_TOP   2
`define ECTM_C0_CKS_MID   1
`define ECTM_C0_CKS_LO    0
`define ECTM_C1_TVEG_HI   4
`define ECTM_C1_TVEG_LO   3
`define ECTM_C1_TRIGGER_ENABLE      2
`define ECTM_C1_ICKS      0
`define ECTM_C1_WMASK     8'h1d
`define ECTM_NUM_EVT      3

// ==========================================================================
// reset values and counts
`define ECTM_RST_BYTE     8'h00
`define ECTM_RST_EVT      3'h0
`define ECTM_RST_OSEL     4'h0
`define ECTM_CNT_ONE      8'h01
`define ECTM_CNT_MAX      8'hff
`define ECTM_ICKS_TAP_OFS 3'h3
`define ECTM_CKS_OFF      2'h0

`endif

/* File: logic/ectm_pkg.sv */
// shared types of the eight bit compare timer
`default_nettype none
`include "ectm_consts.svh"

package ectm_pkg;

  // ========================================================================
  // one register bus request as seen in a cycle
  typedef struct packed {
    logic [`ECTM_ADDR_W-1:0] addr;
    logic [`ECTM_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } ectm_bus_req_t;

  // ========================================================================
  // output pin action on a compare match
  typedef enum logic [1:0] {
    OSEL_KEEP   = 2'b00,
    OSEL_LOW    = 2'b01,
    OSEL_HIGH   = 2'b10,
    OSEL_TOGGLE = 2'b11
  } ectm_osel_t;

  // counter clear condition
  typedef enum logic [1:0] {
    CCLR_NONE = 2'b00,
    CCLR_ON_A = 2'b01,
    CCLR_ON_B = 2'b10,
    CCLR_TRIG = 2'b11
  } ectm_cclr_t;

  // trigger pin edge
  typedef enum logic [1:0] {
    TEDGE_OFF  = 2'b00,
    TEDGE_RISE = 2'b01,
    TEDGE_FALL = 2'b10,
    TEDGE_BOTH = 2'b11
  } ectm_tedge_t;

endpackage : ectm_pkg
`default_nettype wire

/* File: logic/ectm_prescaler.sv */
// free running prescaler giving one-cycle falling edge ticks of each stage
`default_nettype none
`timescale 1ns/1ps

module ectm_prescaler #(
  parameter int unsigned DIV_W = 7  // stages; stage i ticks every 2**(i+1) clocks
) (
  input  wire logic             clk_in,    // system clock
  input  wire logic             rst_n_in,  // async reset, active low
  output wire logic [DIV_W-1:0] tick_out   // one pulse per falling edge of each stage
);

  logic [DIV_W-1:0] div_reg;

  // ========================================================================
  // divider chain runs from reset on and is never stopped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // stage i falls on the next edge when all lower bits and itself are one
  for (genvar i = 0; i < DIV_W; i++) begin : g_tap
    assign tick_out[i] = &div_reg[i:0];
  end

endmodule : ectm_prescaler
`default_nettype wire

/* File: logic/ectm_timer.sv */
// eight bit compare timer with status flags, output pin and register port
// Notes on behaviour
// - compare B match sets its flag
// - compare A match sets its flag
// - counter overflow sets overflow flag
// - flag clears by read-while-set then write zero
// - B output select, 00 keeps pin
// - A output select, 00 keeps, 11 toggles
// - compare constant A readable and writable
// - compare against A on every count
// - eight bit up counter, one per edge
// - trigger edge select, 00 disables trigger
// - trigger enable gates counting to trigger edges
// - clock select 011 with internal gives /128
// - clear field 01 clears counter on A
// - A and B interrupt enables gate requests
// - overflow interrupt enable gates its request
`default_nettype none
`timescale 1ns/1ps
`include "ectm_consts.svh"

module ectm_timer #(
  parameter int unsigned DIV_W = 7  // prescaler stages, top stage is /128
) (
  input  wire logic                    clk_in,                // system clock, 200 MHz
  input  wire logic                    rst_n_in,              // async reset, active low
  input  wire logic [`ECTM_ADDR_W-1:0] bus_addr_in,           // register byte address
  input  wire logic [`ECTM_DATA_W-1:0] bus_wdata_in,          // write data
  input  wire logic                    bus_wr_in,             // write strobe
  input  wire logic                    bus_rd_in,             // read strobe
  output logic      [`ECTM_DATA_W-1:0] bus_rdata_out,         // read data, cycle after strobe
  input  wire logic                    trigger_input_pin_in,  // asynchronous trigger pin
  output logic                         timer_output_pin_out,  // compare driven pin
  output logic                         irq_out                // level interrupt
);

  // ========================================================================
  // bus request bundle and address decode
  ectm_pkg::ectm_bus_req_t req;
  assign req = '{addr: bus_addr_in, wdata: bus_wdata_in,
                 wr: bus_wr_in, rd: bus_rd_in};

  wire logic sel_ctrl0;
  wire logic sel_stat;
  wire logic sel_cora;
  wire logic sel_corb;
  wire logic sel_cnt;
  wire logic sel_ctrl1;
  wire logic sel_irqs;
  wire logic sel_irqm;
  assign sel_ctrl0 = (req.addr == `ECTM_OFF_CTRL0);
  assign sel_stat  = (req.addr == `ECTM_OFF_STAT);
  assign sel_cora  = (req.addr == `ECTM_OFF_CORA);
  assign sel_corb  = (req.addr == `ECTM_OFF_CORB);
  assign sel_cnt   = (req.addr == `ECTM_OFF_CNT);
  assign sel_ctrl1 = (req.addr == `ECTM_OFF_CTRL1);
  assign sel_irqs  = (req.addr == `ECTM_OFF_IRQ_STAT);
  assign sel_irqm  = (req.addr == `ECTM_OFF_IRQ_MASK);

  wire logic wr_stat;
  wire logic rd_stat;
  assign wr_stat = req.wr & sel_stat;
  assign rd_stat = req.rd & sel_stat;

  // ========================================================================
  // register state
  logic [`ECTM_DATA_W-1:0]  ctrl0_reg;      // timer_control_zero
  logic [`ECTM_DATA_W-1:0]  ctrl1_reg;      // timer_control_one
  logic [3:0]               osel_reg;       // output select fields of status
  logic [`ECTM_NUM_EVT-1:0] flag_reg;       // {compare_b, compare_a, overflow}
  logic [`ECTM_NUM_EVT-1:0] armed_reg;      // flag seen set by a status read
  logic [`ECTM_DATA_W-1:0]  cora_reg;       // compare_constant_a
  logic [`ECTM_DATA_W-1:0]  corb_reg;       // compare_constant_b
  logic [`ECTM_DATA_W-1:0]  cnt_reg;        // up_counter
  logic [`ECTM_NUM_EVT-1:0] irq_stat_reg;   // sticky interrupt status
  logic [`ECTM_NUM_EVT-1:0] irq_mask_reg;   // interrupt mask
  logic                     pin_reg;
  logic                     irq_reg;
  logic [`ECTM_DATA_W-1:0]  rdata_reg;
  logic                     trig_s1_reg;
  logic                     trig_s2_reg;
  logic                     trig_prev_reg;

  // ========================================================================
  // control fields
  wire logic [2:0] cks;
  wire logic       icks;
  assign cks  = ctrl0_reg[`ECTM_C0_CKS_TOP:`ECTM_C0_CKS_LO];
  assign icks = ctrl1_reg[`ECTM_C1_ICKS];

  ectm_pkg::ectm_cclr_t  cclr;
  ectm_pkg::ectm_tedge_t tedge;
  ectm_pkg::ectm_osel_t  osel_a;
  ectm_pkg::ectm_osel_t  osel_b;
  assign cclr   = ectm_pkg::ectm_cclr_t'(ctrl0_reg[`ECTM_C0_CCLR_HI:`ECTM_C0_CCLR_LO]);
  assign tedge  = ectm_pkg::ectm_tedge_t'(ctrl1_reg[`ECTM_C1_TVEG_HI:`ECTM_C1_TVEG_LO]);
  assign osel_a = ectm_pkg::ectm_osel_t'(osel_reg[`ECTM_ST_OSA_HI:`ECTM_ST_OSA_LO]);
  assign osel_b = ectm_pkg::ectm_osel_t'(osel_reg[`ECTM_ST_OSB_HI:`ECTM_ST_OSB_LO]);

  // ========================================================================
  // internal clock: prescaler taps, picked by the clock select code
  wire logic [DIV_W-1:0] pre_tick;

  ectm_prescaler #(
    .DIV_W (DIV_W)
  ) ectm_prescaler_i (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tick_out (pre_tick)
  );

  // codes 001..011 pick a tap, internal select shifts three stages down;
  // code 000 and the 1xx codes leave the internal clock stopped
  wire logic       clk_run;
  wire logic [2:0] tap_idx;
  wire logic       clk_tick;
  assign clk_run  = ~cks[`ECTM_C0_CKS_TOP] &
                    (cks[`ECTM_C0_CKS_MID:`ECTM_C0_CKS_LO] != `ECTM_CKS_OFF);
  assign tap_idx  = {1'b0, cks[`ECTM_C0_CKS_MID:`ECTM_C0_CKS_LO]} +
                    (icks ? `ECTM_ICKS_TAP_OFS : 3'h0);
  assign clk_tick = clk_run & pre_tick[tap_idx];

  // ========================================================================
  // trigger pin: two flop synchroniser, edge detect on the second stage only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trig_s1_reg   <= 1'b0;
      trig_s2_reg   <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_s1_reg   <= trigger_input_pin_in;
      trig_s2_reg   <= trig_s1_reg;
      trig_prev_reg <= trig_s2_reg;
    end
  end

  wire logic trig_rise;
  wire logic trig_fall;
  wire logic trig_edge;
  wire logic trig_mode;
  assign trig_rise = trig_s2_reg & ~trig_prev_reg;
  assign trig_fall = ~trig_s2_reg & trig_prev_reg;
  assign trig_edge = ((tedge == ectm_pkg::TEDGE_RISE) & trig_rise) |
                     ((tedge == ectm_pkg::TEDGE_FALL) & trig_fall) |
                     ((tedge == ectm_pkg::TEDGE_BOTH) & (trig_rise | trig_fall));
  // with the trigger enabled and an edge code other than 00, only selected pin edges step the counter
  assign trig_mode = ctrl1_reg[`ECTM_C1_TRIGGER_ENABLE] & (tedge != ectm_pkg::TEDGE_OFF);

  // ========================================================================
  // count step, compare matches and overflow
  wire logic count_tick;
  wire logic match_a;
  wire logic match_b;
  wire logic ovf_evt;
  wire logic cnt_clear;
  assign count_tick = trig_mode ? trig_edge : clk_tick;
  assign match_a    = count_tick & (cnt_reg == cora_reg);
  assign match_b    = count_tick & (cnt_reg == corb_reg);
  assign cnt_clear  = ((cclr == ectm_pkg::CCLR_ON_A) & match_a) |
                      ((cclr == ectm_pkg::CCLR_ON_B) & match_b) |
                      ((cclr == ectm_pkg::CCLR_TRIG) & trig_edge);
  // a clear at the top value is a clear, not an overflow
  assign ovf_evt    = count_tick & (cnt_reg == `ECTM_CNT_MAX) & ~cnt_clear;

  wire logic [`ECTM_NUM_EVT-1:0] evt;
  assign evt = {match_b, match_a, ovf_evt};

  // software load beats the clear, the clear beats the step
  wire logic [`ECTM_DATA_W-1:0] cnt_next;
  assign cnt_next = (req.wr & sel_cnt) ? req.wdata :
                    cnt_clear          ? `ECTM_RST_BYTE :
                    count_tick         ? cnt_reg + `ECTM_CNT_ONE :
                                         cnt_reg;

  // ========================================================================
  // status flags: armed by a read that sees them set, cleared by a later
  // write of zero; a new event in the clearing cycle keeps the flag set
  wire logic [`ECTM_NUM_EVT-1:0] flag_next;
  wire logic [`ECTM_NUM_EVT-1:0] armed_next;
  for (genvar i = 0; i < `ECTM_NUM_EVT; i++) begin : g_flag
    wire logic clr_hit;
    assign clr_hit = wr_stat & armed_reg[i] & ~req.wdata[`ECTM_ST_FLAG_LO + i];
    assign flag_next[i]  = evt[i] | (flag_reg[i] & ~clr_hit);
    assign armed_next[i] = rd_stat ? flag_reg[i] :
                           wr_stat ? 1'b0 : (armed_reg[i] & flag_reg[i]);
  end

  // ========================================================================
  // output pin action; A is applied after B so A wins a level conflict
  function automatic logic pin_act(input ectm_pkg::ectm_osel_t sel, input logic lvl);
    logic res;
    res = lvl;
    unique case (sel)
      ectm_pkg::OSEL_KEEP:   res = lvl;
      ectm_pkg::OSEL_LOW:    res = 1'b0;
      ectm_pkg::OSEL_HIGH:   res = 1'b1;
      ectm_pkg::OSEL_TOGGLE: res = ~lvl;
    endcase
    return res;
  endfunction : pin_act

  wire logic pin_after_b;
  wire logic pin_next;
  assign pin_after_b = match_b ? pin_act(osel_b, pin_reg) : pin_reg;
  assign pin_next    = match_a ? pin_act(osel_a, pin_after_b) : pin_after_b;

  // ========================================================================
  // interrupts: enables gate the raising, write one clears, set wins
  wire logic [`ECTM_NUM_EVT-1:0] irq_set;
  wire logic [`ECTM_NUM_EVT-1:0] irq_clr;
  wire logic [`ECTM_NUM_EVT-1:0] irq_stat_next;
  wire logic [`ECTM_NUM_EVT-1:0] irq_mask_next;
  assign irq_set       = evt & ctrl0_reg[`ECTM_C0_IE_HI:`ECTM_C0_IE_LO];
  assign irq_clr       = (req.wr & sel_irqs) ? req.wdata[`ECTM_NUM_EVT-1:0] : '0;
  assign irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
  assign irq_mask_next = (req.wr & sel_irqm) ? req.wdata[`ECTM_NUM_EVT-1:0] : irq_mask_reg;

  // ========================================================================
  // read data; reserved bits and unmapped addresses read as zero
  wire logic [`ECTM_DATA_W-1:0] stat_view;
  wire logic [`ECTM_DATA_W-1:0] rd_mux;
  assign stat_view = {flag_reg, 1'b0, osel_reg};
  assign rd_mux = sel_ctrl0 ? ctrl0_reg :
                  sel_stat  ? stat_view :
                  sel_cora  ? cora_reg :
                  sel_corb  ? corb_reg :
                  sel_cnt   ? cnt_reg :
                  sel_ctrl1 ? ctrl1_reg :
                  sel_irqs  ? {5'h00, irq_stat_reg} :
                  sel_irqm  ? {5'h00, irq_mask_reg} :
                              `ECTM_RST_BYTE;

  // ========================================================================
  // software written registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl0_reg <= `ECTM_RST_BYTE;
      ctrl1_reg <= `ECTM_RST_BYTE;
      osel_reg  <= `ECTM_RST_OSEL;
      cora_reg  <= `ECTM_RST_BYTE;
      corb_reg  <= `ECTM_RST_BYTE;
    end else begin
      if (req.wr & sel_ctrl0) begin
        ctrl0_reg <= req.wdata;
      end
      if (req.wr & sel_ctrl1) begin
        ctrl1_reg <= req.wdata & `ECTM_C1_WMASK;
      end
      if (wr_stat) begin
        osel_reg <= req.wdata[`ECTM_ST_OSB_HI:`ECTM_ST_OSA_LO];
      end
      if (req.wr & sel_cora) begin
        cora_reg <= req.wdata;
      end
      if (req.wr & sel_corb) begin
        corb_reg <= req.wdata;
      end
    end
  end

  // ========================================================================
  // counter, flags and interrupt state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg      <= `ECTM_RST_BYTE;
      flag_reg     <= `ECTM_RST_EVT;
      armed_reg    <= `ECTM_RST_EVT;
      irq_stat_reg <= `ECTM_RST_EVT;
      irq_mask_reg <= `ECTM_RST_EVT;
    end else begin
      cnt_reg      <= cnt_next;
      flag_reg     <= flag_next;
      armed_reg    <= armed_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ========================================================================
  // output flops; interrupt looks at next state so it follows its cause
  // in the same edge, and read data is held for exactly one cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      rdata_reg <= `ECTM_RST_BYTE;
    end else begin
      pin_reg   <= pin_next;
      irq_reg   <= |(irq_stat_next & irq_mask_next);
      rdata_reg <= req.rd ? rd_mux : `ECTM_RST_BYTE;
    end
  end

  assign timer_output_pin_out = pin_reg;
  assign irq_out              = irq_reg;
  assign bus_rdata_out        = rdata_reg;

endmodule : ectm_timer
`default_nettype wire

/* File: sim/ectm_timer_chk.sv */
// port level checker of the eight bit compare timer, bound to its top module
`default_nettype none
`timescale 1ns/1ps
`include "ectm_consts.svh"

module ectm_timer_chk #(
  parameter int unsigned DIV_W = 7  // prescaler stages, passed on unused
) (
  input wire logic                    clk_in,                // system clock
  input wire logic                    rst_n_in,              // async reset, active low
  input wire logic [`ECTM_ADDR_W-1:0] bus_addr_in,           // register byte address
  input wire logic [`ECTM_DATA_W-1:0] bus_wdata_in,          // write data
  input wire logic                    bus_wr_in,             // write strobe
  input wire logic                    bus_rd_in,             // read strobe
  input wire logic [`ECTM_DATA_W-1:0] bus_rdata_out,         // read data
  input wire logic                    trigger_input_pin_in,  // trigger pin
  input wire logic                    timer_output_pin_out,  // compare driven pin
  input wire logic                    irq_out                // level interrupt
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================================
  // shadows of the plain software registers, rebuilt from bus writes alone
  logic [7:0] cora_sh_reg;
  logic [7:0] ctrl1_sh_reg;
  logic [2:0] mask_sh_reg;
  logic [3:0] osel_sh_reg;
  wire        wr_cora  = bus_wr_in && (bus_addr_in == `ECTM_OFF_CORA);
  wire        wr_ctrl1 = bus_wr_in && (bus_addr_in == `ECTM_OFF_CTRL1);
  wire        wr_mask  = bus_wr_in && (bus_addr_in == `ECTM_OFF_IRQ_MASK);
  wire        wr_stat  = bus_wr_in && (bus_addr_in == `ECTM_OFF_STAT);
  wire        mask_off = (mask_sh_reg == 3'h0);
  wire        osel_off = (osel_sh_reg == 4'h0);

  // shadows follow the write strobe only, so a stuck design register shows up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cora_sh_reg  <= 8'h00;
      ctrl1_sh_reg <= 8'h00;
      mask_sh_reg  <= 3'h0;
      osel_sh_reg  <= 4'h0;
    end else begin
      if (wr_cora) cora_sh_reg <= bus_wdata_in;
      if (wr_ctrl1) ctrl1_sh_reg <= bus_wdata_in;
      if (wr_mask) mask_sh_reg <= bus_wdata_in[2:0];
      if (wr_stat) osel_sh_reg <= bus_wdata_in[3:0];
    end
  end

  // ==========================================================================
  // read sequences of single registers
  sequence s_rd_cora;  bus_rd_in && (bus_addr_in == `ECTM_OFF_CORA);  endsequence
  sequence s_rd_ctrl1; bus_rd_in && (bus_addr_in == `ECTM_OFF_CTRL1); endsequence
  sequence s_rd_stat;  bus_rd_in && (bus_addr_in == `ECTM_OFF_STAT);  endsequence
  sequence s_rd_irq;
    bus_rd_in && ((bus_addr_in == `ECTM_OFF_IRQ_STAT) || (bus_addr_in == `ECTM_OFF_IRQ_MASK));
  endsequence

  a_rdata_idle_zero: assert property (!bus_rd_in |=> bus_rdata_out == 8'h00)
    else $error("read data not zero outside a read answer");
  a_cora_read_back: assert property (s_rd_cora |=> bus_rdata_out == $past(cora_sh_reg))
    else $error("compare constant a read back wrong");
  a_ctrl1_masked: assert property (s_rd_ctrl1 |=> bus_rdata_out == ($past(ctrl1_sh_reg) & 8'h1d))
    else $error("control one read back wrong");
  a_stat_osel_read: assert property (s_rd_stat |=>
    bus_rdata_out[4:0] == {1'b0, $past(osel_sh_reg)})
    else $error("status select field read back wrong");
  a_irq_regs_rsvd: assert property (s_rd_irq |=> bus_rdata_out[7:3] == 5'h00)
    else $error("interrupt register reserved bits not zero");
  a_irq_mask_gate: assert property (mask_off && $past(mask_off) |-> !irq_out)
    else $error("interrupt raised with all sources masked");
  a_pin_keep_idle: assert property (osel_off && $past(osel_off) |->
    $stable(timer_output_pin_out))
    else $error("output pin moved with both selects on keep");
  a_pin_reset_low: assert property ($rose(rst_n_in) |-> !timer_output_pin_out && !irq_out)
    else $error("output pin or interrupt high after reset");
endmodule : ectm_timer_chk

bind ectm_timer ectm_timer_chk #(.DIV_W(DIV_W)) ectm_timer_chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_addr_in(bus_addr_in),
  .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
  .bus_rdata_out(bus_rdata_out), .trigger_input_pin_in(trigger_input_pin_in),
  .timer_output_pin_out(timer_output_pin_out), .irq_out(irq_out)
);
`default_nettype wire

/* File: sim/ectm_timer_test.sv */
// self-checking testbench of the eight bit compare timer
`default_nettype none
`timescale 1ns/1ps
`include "ectm_consts.svh"

module eight_bit_compare_timer_test;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [15:0] addr     = 16'h0000;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        trig     = 1'b0;
  logic [7:0]  rdata;
  logic        pin;
  logic        irq;
  logic [7:0]  got;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          n;

  // ==========================================================================
  // clock, device and stimulus helpers
  always #2.5 clk_in = ~clk_in;

  ectm_timer ectm_timer_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata),
    .trigger_input_pin_in(trig), .timer_output_pin_out(pin), .irq_out(irq)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask : bus_wr

  // read data is taken in the one cycle after the strobe, once that edge has settled
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // whole run is near 1200 cycles, so this margin only trips on a hang
  initial begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    results();
  end

  // ==========================================================================
  // test sequence
  initial begin
    logic [7:0] tv [5];
    logic [7:0] te [5];
    tv = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c};
    te = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h06};
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // reset values, unmapped place and read back of plain registers
    for (int a = 16'hffa0; a <= 16'hffa7; a++) begin
      bus_rd(a[15:0], got);
      check(got, 8'h00);
    end
    check({7'h00, pin}, 8'h00);
    bus_wr(16'hffb0, 8'h55);
    bus_rd(16'hffb0, got);
    check(got, 8'h00);
    bus_wr(`ECTM_OFF_CORA, 8'h8e);
    bus_rd(`ECTM_OFF_CORA, got);
    check(got, 8'h8e);
    bus_wr(`ECTM_OFF_CTRL1, 8'hff);
    bus_rd(`ECTM_OFF_CTRL1, got);
    check(got, 8'h1d);
    // toggle on match a every third tick of the /128 clock, counter cleared on a
    bus_wr(`ECTM_OFF_CTRL0, 8'h0b);
    bus_wr(`ECTM_OFF_CTRL1, 8'h01);
    bus_wr(`ECTM_OFF_CORA, 8'h02);
    bus_wr(`ECTM_OFF_CORB, 8'h00);
    bus_wr(`ECTM_OFF_CNT, 8'h00);
    bus_wr(`ECTM_OFF_STAT, 8'h03);
    n = 0;
    while (pin !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1 n++;
    end
    n = 0;
    while (pin !== 1'b0 && n < 2000) begin
      @(posedge clk_in);
      #1 n++;
    end
    check(n[7:0], 8'h80);
    check({7'h00, n > 255}, 8'h01);
    bus_rd(`ECTM_OFF_STAT, got);
    check(got, 8'hc3);
    bus_rd(`ECTM_OFF_IRQ_STAT, got);
    check(got, 8'h00);
    bus_wr(`ECTM_OFF_STAT, 8'h00);
    bus_wr(`ECTM_OFF_CTRL0, 8'h00);
    // internal select off gives the /4 tap, so a dozen cycles do overflow
    bus_wr(`ECTM_OFF_CTRL1, 8'h00);
    // overflow with its interrupt enable off, then the two step flag clear
    bus_wr(`ECTM_OFF_CTRL0, 8'h01);
    bus_wr(`ECTM_OFF_CNT, 8'hfe);
    repeat (12) @(posedge clk_in);
    bus_wr(`ECTM_OFF_CTRL0, 8'h00);
    bus_rd(`ECTM_OFF_CNT, got);
    check({4'h0, got[7:4]}, 8'h00);
    bus_rd(`ECTM_OFF_IRQ_STAT, got);
    check(got, 8'h00);
    bus_wr(`ECTM_OFF_STAT, 8'h00);
    bus_rd(`ECTM_OFF_STAT, got);
    check(got & 8'h20, 8'h20);
    bus_wr(`ECTM_OFF_STAT, 8'h00);
    bus_rd(`ECTM_OFF_STAT, got);
    check(got & 8'h20, 8'h00);
    // overflow with the enable on: interrupt status, mask and write one clear
    bus_wr(`ECTM_OFF_CTRL0, 8'h21);
    bus_wr(`ECTM_OFF_CNT, 8'hfe);
    repeat (12) @(posedge clk_in);
    bus_wr(`ECTM_OFF_CTRL0, 8'h00);
    bus_rd(`ECTM_OFF_STAT, got);
    check(got & 8'h20, 8'h20);
    bus_rd(`ECTM_OFF_IRQ_STAT, got);
    check(got & 8'h01, 8'h01);
    check({7'h00, irq}, 8'h00);
    bus_wr(`ECTM_OFF_IRQ_MASK, 8'hff);
    repeat (2) @(posedge clk_in);
    check({7'h00, irq}, 8'h01);
    bus_rd(`ECTM_OFF_IRQ_MASK, got);
    check(got, 8'h07);
    bus_wr(`ECTM_OFF_IRQ_STAT, 8'h07);
    repeat (2) @(posedge clk_in);
    check({7'h00, irq}, 8'h00);
    bus_rd(`ECTM_OFF_IRQ_STAT, got);
    check(got, 8'h00);
    // match b drives the pin high while the a select keeps it
    check({7'h00, pin}, 8'h00);
    bus_wr(`ECTM_OFF_STAT, 8'h08);
    bus_wr(`ECTM_OFF_CTRL0, 8'h01);
    bus_wr(`ECTM_OFF_CNT, 8'h00);
    repeat (8) @(posedge clk_in);
    bus_wr(`ECTM_OFF_CTRL0, 8'h00);
    check({7'h00, pin}, 8'h01);
    // trigger pin counting for each edge code, internal clock stopped
    for (int k = 0; k < 5; k++) begin
      bus_wr(`ECTM_OFF_CTRL1, tv[k]);
      bus_wr(`ECTM_OFF_CNT, 8'h00);
      repeat (3) begin
        repeat (8) @(posedge clk_in);
        trig <= 1'b1;
        repeat (8) @(posedge clk_in);
        trig <= 1'b0;
      end
      repeat (8) @(posedge clk_in);
      bus_rd(`ECTM_OFF_CNT, got);
      check(got, te[k]);
    end
    results();
  end
endmodule : eight_bit_compare_timer_test
`default_nettype wire
